// ### rtl/sspi_pkg.sv
// Purpose: Shared constants and types of the SPI serial port
// Assumes: mclk at 40 MHz
// Notes: Register indices; byte address is four times the index
package sspi_pkg;
    localparam int MCLK_MHZ = 40;
    // Register indices
    localparam logic [7:0] IDX_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_BUF = 8'h13;
    localparam logic [7:0] IDX_CTRL = 8'h14;
    localparam logic [7:0] IDX_STAT = 8'h94;
    // Field positions
    localparam int CTRL_WRITE_COLLISION_FLAG = 7;
    localparam int CTRL_OV = 6;
    localparam int STAT_SMP = 7;
    localparam int STAT_CKE = 6;
    localparam int FLAG_IRQ = 3;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] SYNC_RST = 4'h1;
    // Half bit periods in mclk cycles
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    // Select held high this long resets the slave bit count
    localparam int SS_RESET_NS = 1000;
    localparam int SS_RESET_CYC = (SS_RESET_NS * MCLK_MHZ + 999) / 1000;
    localparam int SS_CNT_W = $clog2(SS_RESET_CYC + 1);

    typedef enum logic [3:0] {
        M_DIV4 = 4'h0,
        M_DIV16 = 4'h1,
        M_DIV64 = 4'h2,
        M_TMR = 4'h3,
        S_SS = 4'h4,
        S_NOSS = 4'h5
    } sspi_mode_e;

    typedef enum logic {
        MS_IDLE = 1'b0,
        MS_RUN = 1'b1
    } sspi_mst_e;

    typedef struct packed {
        logic write_collision_flag;
        logic ov;
        logic en;
        logic clock_polarity;
        logic [3:0] mode;
    } sspi_ctrl_s;

    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
    } sspi_pin_in_s;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } sspi_pin_out_s;
endpackage

// ### rtl/sspi_port.sv
// Purpose: SPI mode of a synchronous serial port, AXI4-Lite registers
// Assumes: Pins resolved outside; timer_two_tick is a one-cycle pulse
// Notes: Pin inputs pass four flops, so the fastest master rate samples late
// Function
// - Master samples at middle, or at end of output time when sample_phase set
// - Edge select with polarity picks the transmit edge of the clock
// - Polarity bit sets the idle level of the serial clock
// - Mode codes 0 to 3 give master clock of div 4, 16, 64, timer/2
// - Code 4 is slave with select, code 5 slave without select
// - Port enable hands pins to the port; clear returns them to I/O
// - Data write during a shift is dropped and sets write collision
// - Slave byte completing with buffer full sets overflow and is lost
// - Overflow is never set in master mode
// - Master data write starts a full duplex transfer
// - Eight bits per transfer, MSb first, through one shift register
// - Eighth bit moves byte to buffer, sets buffer full and irq flag
// - Receive is double buffered so the next byte may shift in
// - Reading the data buffer clears buffer full
// - Shift register is reached only through the data buffer address
// - Master drives the serial clock; slave takes it as input
// - High select floats data out and pauses; low select resumes
// - Select held high in select mode resets the slave bit count
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module sspi_port #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input logic mclk,
    input logic rst_n,
    // AXI4-Lite write
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // AXI4-Lite read
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Timer and serial pins
    input logic timer_two_tick,
    input sspi_pkg::sspi_pin_in_s pins_i,
    output sspi_pkg::sspi_pin_out_s pins_o
);
    import sspi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    sspi_ctrl_s ctrl_r, ctrl_nxt;
    sspi_mst_e mst_r, mst_nxt;
    logic smp_r, cke_r, bf_r, irq_r, sdo_r, sck_r, sck_d_r;
    logic [7:0] buf_r, sr_r;
    logic [3:0] cnt_r;
    logic [4:0] h_r;
    logic [5:0] div_r;
    logic [2:0] sy1_r, sy2_r, sy3_r, filt_r, filt_nxt;
    logic [SS_CNT_W-1:0] ss_cnt_r;
    logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_data_r, rdata_r;
    logic w_strb_r;
    logic [1:0] bresp_r, rresp_r;

    function automatic logic idx_known(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        return (a[ADDR_W-1:10] == '0) &&
            (i == IDX_FLAGS || i == IDX_BUF || i == IDX_CTRL || i == IDX_STAT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register bus decode
    wire [7:0] aw_idx = aw_addr_r[9:2];
    wire aw_ok = idx_known(aw_addr_r);
    wire wr_fire = aw_got_r && w_got_r && !bvalid_r;
    wire wr_en = wr_fire && aw_ok && w_strb_r;
    wire buf_wr = wr_en && aw_idx == IDX_BUF;
    wire ctrl_wr = wr_en && aw_idx == IDX_CTRL;
    wire stat_wr = wr_en && aw_idx == IDX_STAT;
    wire flag_wr = wr_en && aw_idx == IDX_FLAGS;
    wire [7:0] wd = w_data_r;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire [7:0] ar_idx = s_axi_araddr[9:2];
    wire ar_ok = idx_known(s_axi_araddr);
    wire buf_rd = rd_fire && ar_ok && ar_idx == IDX_BUF;

    // Mode decode
    wire is_master = ctrl_r.mode[3:2] == 2'b00;
    wire is_slave = ctrl_r.mode == S_SS || ctrl_r.mode == S_NOSS;
    wire ss_mode = ctrl_r.mode == S_SS;
    wire tx_on_rise = ctrl_r.clock_polarity ^ cke_r;

    // Synchronised pins: sck, sdi, ss_n
    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_filt
        assign filt_nxt[gi] = (sy2_r[gi] == sy3_r[gi]) ? sy2_r[gi] : filt_r[gi];
    end
    wire sck_f = filt_r[2];
    wire sdi_f = filt_r[1];
    wire ss_f = filt_r[0];

    // Master bit clock
    wire [5:0] half = (ctrl_r.mode == M_DIV4) ? HALF_DIV4 :
        (ctrl_r.mode == M_DIV16) ? HALF_DIV16 : HALF_DIV64;
    wire m_busy = mst_r == MS_RUN;
    wire m_tick = m_busy && ((ctrl_r.mode == M_TMR) ? timer_two_tick :
        (div_r == half - 6'h01));
    wire m_edge = m_tick && !h_r[4];
    wire m_tx = m_edge && ((!sck_r) == tx_on_rise);
    wire m_smp = smp_r ? ((m_tx && h_r != 5'h00) || (m_tick && h_r[4])) :
        (m_edge && !m_tx);

    // Slave edges
    wire s_act = ctrl_r.en && is_slave && !(ss_mode && ss_f);
    wire s_rise = sck_f && !sck_d_r;
    wire s_fall = !sck_f && sck_d_r;
    wire s_edge = s_act && (s_rise || s_fall);
    wire s_tx = s_edge && (s_rise == tx_on_rise);
    wire s_smp = s_edge && !s_tx;

    // Shared shift path
    wire do_smp = m_smp || s_smp;
    wire do_tx = m_tx || s_tx;
    wire [3:0] cnt_plus = do_smp ? cnt_r + 4'h1 : cnt_r;
    wire [7:0] shifted = {sr_r[6:0], sdi_f};
    wire [7:0] done_byte = do_smp ? shifted : sr_r;
    wire m_done = m_tick && h_r >= 5'h0F && cnt_plus == 4'h8;
    wire s_done = s_smp && cnt_r == 4'h7;
    wire done = m_done || s_done;
    wire busy_any = m_busy || cnt_r != 4'h0;
    wire ov_event = s_done && bf_r;
    wire write_ok = buf_wr && !busy_any;
    wire write_collision_flag_set = buf_wr && busy_any;
    wire m_start = write_ok && ctrl_r.en && is_master;
    wire ss_rst = ss_mode && ss_f && ss_cnt_r == SS_CNT_W'(SS_RESET_CYC - 1);

    // Control next value; set wins over a software clear
    assign ctrl_nxt.write_collision_flag = write_collision_flag_set | (ctrl_r.write_collision_flag & ~(ctrl_wr & ~wd[CTRL_WRITE_COLLISION_FLAG]));
    assign ctrl_nxt.ov = ov_event | (ctrl_r.ov & ~(ctrl_wr & ~wd[CTRL_OV]));
    assign ctrl_nxt.en = ctrl_wr ? wd[5] : ctrl_r.en;
    assign ctrl_nxt.clock_polarity = ctrl_wr ? wd[4] : ctrl_r.clock_polarity;
    assign ctrl_nxt.mode = ctrl_wr ? wd[3:0] : ctrl_r.mode;

    // Read data
    wire [7:0] stat_rd = {smp_r, cke_r, 5'h00, bf_r};
    wire [7:0] flag_rd = {4'h0, irq_r, 3'h0};
    wire [7:0] rd_byte = (ar_idx == IDX_BUF) ? buf_r :
        (ar_idx == IDX_CTRL) ? ctrl_r :
        (ar_idx == IDX_STAT) ? stat_rd : flag_rd;

    // Pins
    assign pins_o.sck_o = sck_r;
    assign pins_o.sck_oe = ctrl_r.en && is_master;
    assign pins_o.sdo_o = sdo_r;
    assign pins_o.sdo_oe = ctrl_r.en && (is_master || s_act);

    // Bus outputs
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = {24'h000000, rdata_r};
    assign s_axi_rresp = rresp_r;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            aw_addr_r <= '0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_strb_r <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= aw_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
            rresp_r <= 2'h0;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= ar_ok ? rd_byte : 8'h00;
            rresp_r <= ar_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and flags
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            smp_r <= 1'b0;
            cke_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (stat_wr) begin
                smp_r <= wd[STAT_SMP];
                cke_r <= wd[STAT_CKE];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bf_r <= 1'b0;
            irq_r <= 1'b0;
            buf_r <= 8'h00;
        end else begin
            if (done && !ov_event) buf_r <= done_byte;
            if (done) bf_r <= 1'b1;
            else if (buf_rd) bf_r <= 1'b0;
            if (done) irq_r <= 1'b1;
            else if (flag_wr && !wd[FLAG_IRQ]) irq_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master sequencer
    always_comb begin
        mst_nxt = mst_r;
        case (mst_r)
            MS_IDLE: if (m_start) mst_nxt = MS_RUN;
            MS_RUN: if (m_done || !ctrl_r.en || !is_master) mst_nxt = MS_IDLE;
            default: mst_nxt = MS_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mst_r <= MS_IDLE;
            h_r <= 5'h00;
            div_r <= 6'h00;
            sck_r <= 1'b0;
        end else begin
            mst_r <= mst_nxt;
            h_r <= !m_busy ? 5'h00 : (m_tick ? h_r + 5'h01 : h_r);
            div_r <= (!m_busy || m_tick) ? 6'h00 : div_r + 6'h01;
            if (!m_busy) sck_r <= ctrl_r.clock_polarity;
            else if (m_edge) sck_r <= !sck_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift register and pin synchronisers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sr_r <= 8'h00;
            sdo_r <= 1'b0;
            cnt_r <= 4'h0;
        end else begin
            if (write_ok) sr_r <= wd;
            else if (do_smp) sr_r <= shifted;
            if (write_ok) sdo_r <= wd[7];
            else if (do_tx) sdo_r <= do_smp ? sr_r[6] : sr_r[7];
            if (!ctrl_r.en || done || ss_rst || m_start) cnt_r <= 4'h0;
            else if (do_smp) cnt_r <= cnt_plus;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sy1_r <= SYNC_RST[2:0];
            sy2_r <= SYNC_RST[2:0];
            sy3_r <= SYNC_RST[2:0];
            filt_r <= SYNC_RST[2:0];
            sck_d_r <= 1'b0;
            ss_cnt_r <= '0;
        end else begin
            sy1_r <= pins_i;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            filt_r <= filt_nxt;
            sck_d_r <= sck_f;
            if (!(ss_mode && ss_f)) ss_cnt_r <= '0;
            else if (ss_cnt_r != SS_CNT_W'(SS_RESET_CYC)) ss_cnt_r <= ss_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_write_collision_flag_set: assert property (write_collision_flag_set |=> ctrl_r.write_collision_flag)
        else $error("collision flag not set");
    a_ov_master: assert property ($rose(ctrl_r.ov) |-> $past(is_slave))
        else $error("overflow set outside slave mode");
    a_ov_lost: assert property (ov_event |=> ctrl_r.ov && buf_r == $past(buf_r))
        else $error("overflow byte not dropped");
    a_buf_load: assert property (done && !ov_event |=> buf_r == $past(done_byte) && bf_r && irq_r)
        else $error("byte not loaded");
    a_bf_read: assert property (buf_rd && !done |=> !bf_r)
        else $error("buffer full not cleared");
    a_sck_idle: assert property (ctrl_r.en && is_master && !m_busy ##1 !m_busy |-> pins_o.sck_o == $past(ctrl_r.clock_polarity))
        else $error("clock not idle");
    a_sck_dir: assert property (ctrl_r.en |-> pins_o.sck_oe == is_master)
        else $error("clock direction wrong");
    a_pins_off: assert property (!ctrl_r.en |-> !pins_o.sck_oe && !pins_o.sdo_oe)
        else $error("pins driven while disabled");
    a_ss_float: assert property (ss_mode && ss_f |-> !pins_o.sdo_oe && !s_edge)
        else $error("data out driven while deselected");
    a_fast_len: assert property (m_start && ctrl_r.mode == M_DIV4 && !smp_r && !ctrl_wr
        |=> m_busy[*8] ##24 m_busy ##1 !m_busy)
        else $error("master byte length wrong");
    a_tx_edge: assert property (m_busy && $past(m_busy) && $changed(sdo_r)
        |-> $past(m_tx) && pins_o.sck_o == tx_on_rise)
        else $error("data changed off transmit edge");

    c_master_done: cover property (m_done);
    c_slave_done: cover property (s_done && !bf_r);
    c_overflow: cover property (ov_event);
    c_collision: cover property (write_collision_flag_set);
    c_ss_pause: cover property (ss_mode && ss_f && cnt_r != 4'h0);
endmodule

// ### tb/sspi_far_end.sv
// Purpose: Far party of the link, SPI slave or SPI master
// Assumes: Port clock edges are seen on mclk
// Notes: Slave role follows sck_in; master role runs by task
`timescale 1ns/1ps
module sspi_far_end (
    // Clock
    input logic mclk,
    // Link
    input logic sck_in,
    input logic sdo_in,
    output logic sck_out,
    output logic ss_n,
    output logic sdi
);
    logic clock_polarity = 1'h0;
    logic cke = 1'h0;
    logic slv_en = 1'h0;
    logic sq = 1'h0;
    logic [7:0] tx_r = 8'h00;
    logic [7:0] rx_r = 8'h00;
    int cnt = 0;
    initial begin
        sck_out = 1'h0;
        ss_n = 1'h1;
        sdi = 1'h0;
    end
    task automatic load(input logic [7:0] b);
        tx_r <= b;
        cnt <= 0;
        sdi <= b[7];
    endtask
    ////////////////////////////////////////////////////////////
    // Slave role, transmit edge before the first sample keeps bit 7
    always @(posedge mclk) begin
        sq <= sck_in;
        if (slv_en && sck_in != sq) begin
            if (sck_in == (clock_polarity ^ cke)) begin
                if (cnt != 0) begin
                    sdi <= tx_r[6];
                    tx_r <= tx_r << 1;
                end
            end else begin
                rx_r <= {rx_r[6:0], sdo_in};
                cnt <= cnt + 1;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // Master role, clock stands at idle level between bits
    task automatic mst_bits(input int n, input int h);
        repeat (n) begin
            repeat (h) @(posedge mclk);
            sck_out <= ~clock_polarity;
            rx_r <= {rx_r[6:0], sdo_in};
            repeat (h) @(posedge mclk);
            sck_out <= clock_polarity;
            sdi <= tx_r[6];
            tx_r <= tx_r << 1;
        end
    endtask
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench of the SPI serial port
// Assumes: AXI4-Lite master tasks, far party model on the pins
// Notes: Master data checked at div16 and div64 only
`timescale 1ns/1ps
module tb;
    import sspi_pkg::*;
    localparam int LIMIT = 30000;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, tick = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata;
    sspi_pin_in_s pin_in;
    sspi_pin_out_s pin_out;
    logic far_sck, far_ss_n, far_sdi, sdo_w;
    logic sdo_last = 1'h0, sq = 1'h0;
    int fails = 0, check_count = 0, cyc = 0, edges = 0, gap = 0, run = 0;
    logic [7:0] rd;
    always #12.5 mclk = ~mclk;
    sspi_port u_dut (
        .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer_two_tick(tick), .pins_i(pin_in), .pins_o(pin_out)
    );
    sspi_far_end u_far (
        .mclk(mclk), .sck_in(pin_in.sck), .sdo_in(sdo_w), .sck_out(far_sck),
        .ss_n(far_ss_n), .sdi(far_sdi)
    );
    assign pin_in.sck = pin_out.sck_oe ? pin_out.sck_o : far_sck;
    assign pin_in.sdi = far_sdi;
    assign pin_in.ss_n = far_ss_n;
    assign sdo_w = pin_out.sdo_oe ? pin_out.sdo_o : ~sdo_last;
    ////////////////////////////////////////////////////////////
    // Timer ticks, clock edge monitor, timeout
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 4 == 3);
        sq <= pin_out.sck_o;
        run <= run + 1;
        if (pin_out.sdo_oe) sdo_last <= pin_out.sdo_o;
        if (pin_out.sck_o != sq) begin
            edges <= edges + 1;
            gap <= run + 1;
            run <= 0;
        end
        if (cyc == LIMIT) begin
            fails++;
            results();
        end
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        awaddr <= ad(idx);
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rr(input logic [7:0] idx);
        araddr <= ad(idx);
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rd = rdata[7:0];
        rs = rresp;
    endtask
    task automatic ex(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e,
                      input logic [1:0] er);
        rr(idx);
        chk("rdata", {24'h0, e & m}, {24'h0, rd & m});
        chk("rresp", {30'h0, er}, {30'h0, rs});
    endtask
    task automatic wait_bf();
        do rr(IDX_STAT); while (rd[0] !== 1'h1);
    endtask
    ////////////////////////////////////////////////////////////
    // One master transfer with a colliding write
    task automatic mst(input logic [7:0] ctl, input logic [7:0] st, input logic [7:0] tx,
                       input logic [7:0] ftx, input int half, input logic dat);
        wr(IDX_CTRL, 8'h00, 2'h0);
        wr(IDX_STAT, st, 2'h0);
        wr(IDX_CTRL, ctl, 2'h0);
        repeat (2) @(posedge mclk);
        u_far.clock_polarity = ctl[4];
        u_far.cke = st[6];
        u_far.slv_en = 1'h1;
        u_far.load(ftx);
        chk("sck_idle", {31'h0, ctl[4]}, {31'h0, pin_out.sck_o});
        chk("sck_oe", 32'h1, {31'h0, pin_out.sck_oe});
        edges = 0;
        wr(IDX_BUF, tx, 2'h0);
        wr(IDX_BUF, ~tx, 2'h0);
        wait_bf();
        chk("edges", 32'h10, 32'(edges));
        chk("half", 32'(half), 32'(gap));
        chk("sck_end", {31'h0, ctl[4]}, {31'h0, pin_out.sck_o});
        if (dat) chk("far_rx", {24'h0, tx}, {24'h0, u_far.rx_r});
        ex(IDX_FLAGS, 8'h08, 8'h08, 2'h0);
        wr(IDX_FLAGS, 8'h00, 2'h0);
        ex(IDX_BUF, {8{dat}}, ftx, 2'h0);
        ex(IDX_STAT, 8'hFF, st, 2'h0);
        ex(IDX_CTRL, 8'hFF, {2'h2, ctl[5:0]}, 2'h0);
    endtask
    task automatic results();
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        ex(IDX_CTRL, 8'hFF, CTRL_RST, 2'h0);
        ex(IDX_STAT, 8'hFF, 8'h00, 2'h0);
        ex(IDX_FLAGS, 8'h08, 8'h00, 2'h0);
        ex(8'h20, 8'hFF, 8'h00, 2'h2);
        wr(8'h20, 8'h55, 2'h2);
        wr(IDX_STAT, 8'hFF, 2'h0);
        ex(IDX_STAT, 8'hFF, 8'hC0, 2'h0);
        wr(IDX_CTRL, 8'hFF, 2'h0);
        ex(IDX_CTRL, 8'hFF, 8'h3F, 2'h0);
        for (int i = 0; i < 8; i++) begin
            mst({3'h1, i[0], 4'h1}, {i[2], i[1], 6'h00}, 8'hA5 ^ i[7:0], 8'h3C + i[7:0], 8, 1'h1);
        end
        mst(8'h20, 8'h00, 8'h96, 8'h69, 2, 1'h0);
        mst(8'h22, 8'h00, 8'h81, 8'h7E, 32, 1'h1);
        mst(8'h23, 8'h00, 8'h42, 8'hBD, 4, 1'h0);
        wr(IDX_CTRL, 8'h01, 2'h0);
        chk("oe", 32'h0, {30'h0, pin_out.sck_oe, pin_out.sdo_oe});
        wr(IDX_STAT, 8'h00, 2'h0);
        wr(IDX_CTRL, 8'h24, 2'h0);
        u_far.slv_en = 1'h0;
        u_far.clock_polarity = 1'h0;
        u_far.cke = 1'h0;
        chk("sck_oe", 32'h0, {31'h0, pin_out.sck_oe});
        u_far.load(8'h5A);
        wr(IDX_BUF, 8'hC3, 2'h0);
        u_far.ss_n <= 1'h0;
        u_far.mst_bits(8, 8);
        wait_bf();
        chk("far_rx", 32'hC3, {24'h0, u_far.rx_r});
        u_far.load(8'h11);
        u_far.mst_bits(8, 8);
        repeat (16) @(posedge mclk);
        ex(IDX_CTRL, 8'hFF, 8'h64, 2'h0);
        ex(IDX_BUF, 8'hFF, 8'h5A, 2'h0);
        wr(IDX_CTRL, 8'h24, 2'h0);
        ex(IDX_CTRL, 8'hFF, 8'h24, 2'h0);
        u_far.load(8'hE7);
        wr(IDX_BUF, 8'h18, 2'h0);
        u_far.mst_bits(4, 8);
        repeat (8) @(posedge mclk);
        u_far.ss_n <= 1'h1;
        repeat (10) @(posedge mclk);
        chk("sdo_oe", 32'h0, {31'h0, pin_out.sdo_oe});
        wr(IDX_BUF, 8'h00, 2'h0);
        u_far.ss_n <= 1'h0;
        u_far.mst_bits(4, 8);
        wait_bf();
        chk("far_rx", 32'h18, {24'h0, u_far.rx_r});
        ex(IDX_BUF, 8'hFF, 8'hE7, 2'h0);
        ex(IDX_CTRL, 8'hFF, 8'hA4, 2'h0);
        u_far.ss_n <= 1'h1;
        wr(IDX_CTRL, 8'h25, 2'h0);
        repeat (8) @(posedge mclk);
        chk("sdo_oe", 32'h1, {31'h0, pin_out.sdo_oe});
        results();
    end
endmodule
